/* File: src/srg_host.sv */
// Host controller for the flash secured region and its write guards.
// Assumes an external supply monitor and the flash pins on one board.
`include "srg_params.svh"
module srg_host
   import srg_pkg::*;
#(
   parameter logic [7:0] ENTER_CMD = 8'h88,
   parameter logic [7:0] EXIT_CMD = 8'h90,
   parameter logic [7:0] EXIT_CMD2 = 8'h00,
   parameter logic [7:0] PROG_CMD = 8'ha0,
   parameter logic [7:0] LOCK_CMD = 8'h60,
   parameter logic TOP_BOOT = 1'b0
)
(
   input wire logic mclk_i,
   input wire logic resetn_i,
   // Command port
   input wire logic start_i,
   input wire srg_op_t op_i,
   input wire logic [7:0] offs_i,
   input wire logic [7:0] wdata_i,
   output logic busy_o,
   output logic done_o,
   output logic err_o,
   output logic [7:0] rdata_o,
   output logic overlay_o,
   output logic factory_locked_o,
   // Supply monitor
   input wire logic lockout_i,
   // Flash pins
   output logic ce_n_o,
   output logic oe_n_o,
   output logic we_n_o,
   output logic [21:0] addr_o,
   output logic [7:0] dq_o,
   output logic dq_oe_o,
   input wire logic [7:0] dq_i
);
   srg_bus_if bus ();
   srg_cycle u_cycle (
      .mclk_i(mclk_i),
      .resetn_i(resetn_i),
      .bus(bus),
      .ce_n_o(ce_n_o),
      .oe_n_o(oe_n_o),
      .we_n_o(we_n_o),
      .addr_o(addr_o),
      .dq_o(dq_o),
      .dq_oe_o(dq_oe_o),
      .dq_i(dq_i)
   );
   typedef enum logic [1:0] {SRG_S_IDLE, SRG_S_ISSUE, SRG_S_WAIT} srg_st_t;
   srg_st_t st_reg, st_next;
   srg_op_t op_reg, op_next;
   logic [2:0] step_reg, step_next;
   logic [7:0] offs_reg, offs_next, wd_reg, wd_next, rd_reg, rd_next;
   logic ovl_reg, ovl_next, fl_reg, fl_next, err_reg, err_next;
   logic done_reg, done_next, req_reg, req_next;
   logic busy_reg, busy_next, ind_reg, ind_next;
   logic [2:0] nsteps;
   logic last_wr;
   logic [21:0] base, step_a;
   logic [7:0] step_d;
   logic step_w;
   // Region sits at the serial-number corner of the boot area
   assign base = TOP_BOOT ? `SRG_SN_TOP_BYTE : `SRG_SN_BOT_BYTE;
   always_comb begin
      // Every sequence except a read opens with two unlock writes
      step_w = 1'b1;
      step_a = `SRG_UNLK_A1;
      step_d = `SRG_UNLK_D1;
      nsteps = 3'd3;
      case (step_reg)
         3'd0: begin
            step_a = `SRG_UNLK_A1;
            step_d = `SRG_UNLK_D1;
         end
         3'd1: begin
            step_a = `SRG_UNLK_A2;
            step_d = `SRG_UNLK_D2;
         end
         default: begin
            step_a = `SRG_UNLK_A1;
            step_d = ENTER_CMD;
         end
      endcase
      case (op_reg)
         SRG_OP_READ: begin
            nsteps = 3'd1;
            step_w = 1'b0;
            // Overlay maps region onto boot addresses
            step_a = base | {14'h0000, offs_reg};
         end
         SRG_OP_ENTER: nsteps = 3'd3;
         SRG_OP_EXIT: begin
            nsteps = 3'd4;
            if (step_reg == 3'd2) step_d = EXIT_CMD;
            if (step_reg == 3'd3) step_d = EXIT_CMD2;
         end
         SRG_OP_PROG, SRG_OP_LOCK: begin
            // Standard unlocked sequence only, no bypass path
            nsteps = 3'd4;
            if (step_reg == 3'd2) begin
               step_d = (op_reg == SRG_OP_PROG) ? PROG_CMD : LOCK_CMD;
            end
            if (step_reg == 3'd3) begin
               step_a = base | {14'h0000, offs_reg};
               step_d = wd_reg;
            end
         end
         default: nsteps = 3'd1;
      endcase
   end
   assign last_wr = (step_reg == nsteps - 3'd1);
   always_comb begin
      st_next = st_reg;
      op_next = op_reg;
      step_next = step_reg;
      offs_next = offs_reg;
      wd_next = wd_reg;
      rd_next = rd_reg;
      ovl_next = ovl_reg;
      fl_next = fl_reg;
      err_next = 1'b0;
      done_next = 1'b0;
      req_next = 1'b0;
      ind_next = ind_reg;
      if (lockout_i) begin
         // Supply low: flash resets, overlay lost, no new sequence started; a request already in issue still goes out
         st_next = (st_reg == SRG_S_WAIT) ? SRG_S_WAIT : SRG_S_IDLE;
         ovl_next = 1'b0;
      end
      case (st_reg)
         SRG_S_IDLE: begin
            if (start_i && !lockout_i) begin
               op_next = op_i;
               offs_next = offs_i;
               wd_next = wdata_i;
               step_next = 3'd0;
               // Unknown op, or region not in view, aborts the sequence
               if (op_i > SRG_OP_LOCK) begin
                  err_next = 1'b1;
                  done_next = 1'b1;
               end else if ((op_i == SRG_OP_PROG || op_i == SRG_OP_LOCK)
                  && (fl_reg || !ovl_reg)) begin
                  // Factory or customer lock: region is read-only
                  err_next = 1'b1;
                  done_next = 1'b1;
               end else if ((op_i == SRG_OP_READ || op_i == SRG_OP_EXIT)
                  && !ovl_reg) begin
                  err_next = 1'b1;
                  done_next = 1'b1;
               end else begin
                  st_next = SRG_S_ISSUE;
               end
            end
         end
         SRG_S_ISSUE: begin
            req_next = 1'b1;
            st_next = SRG_S_WAIT;
         end
         SRG_S_WAIT: begin
            if (bus.done) begin
               ind_next = 1'b0;
               if (lockout_i) begin
                  err_next = 1'b1;
                  done_next = 1'b1;
                  st_next = SRG_S_IDLE;
               end else if (last_wr) begin
                  done_next = 1'b1;
                  st_next = SRG_S_IDLE;
                  if (op_reg == SRG_OP_READ) rd_next = bus.rdata;
                  if (op_reg == SRG_OP_ENTER) begin
                     ovl_next = 1'b1;
                     ind_next = 1'b1;
                     // Indicator comes back on data line seven
                     st_next = SRG_S_ISSUE;
                     op_next = SRG_OP_READ;
                     offs_next = 8'h00;
                     step_next = 3'd0;
                     done_next = 1'b0;
                  end
                  if (op_reg == SRG_OP_READ && !ovl_reg) begin
                     rd_next = rd_reg;
                  end
                  // Overlay dropped before any main array access
                  if (op_reg == SRG_OP_EXIT) ovl_next = 1'b0;
                  if (op_reg == SRG_OP_LOCK) fl_next = 1'b1;
               end else begin
                  step_next = step_reg + 3'd1;
                  st_next = SRG_S_ISSUE;
               end
            end
         end
         default: st_next = SRG_S_IDLE;
      endcase
      // Only the read chained after enter carries the indicator;
      // a stored byte at offset zero must never look like a lock
      if (st_reg == SRG_S_WAIT && bus.done && ind_reg && !lockout_i) begin
         fl_next = bus.rdata[`SRG_IND_BIT] | fl_reg;
      end
      busy_next = (st_next != SRG_S_IDLE);
   end
   assign bus.req = req_reg;
   assign bus.wr = step_w;
   assign bus.addr = step_a;
   assign bus.wdata = step_d;
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         // Start as after power-up: read-array, no overlay
         st_reg <= SRG_S_IDLE;
         op_reg <= SRG_OP_READ;
         step_reg <= 3'd0;
         offs_reg <= 8'h00;
         wd_reg <= 8'h00;
         rd_reg <= 8'h00;
         ovl_reg <= 1'b0;
         fl_reg <= 1'b0;
         err_reg <= 1'b0;
         done_reg <= 1'b0;
         req_reg <= 1'b0;
         busy_reg <= 1'b0;
         ind_reg <= 1'b0;
      end else begin
         st_reg <= st_next;
         op_reg <= op_next;
         step_reg <= step_next;
         offs_reg <= offs_next;
         wd_reg <= wd_next;
         rd_reg <= rd_next;
         ovl_reg <= ovl_next;
         fl_reg <= fl_next;
         err_reg <= err_next;
         done_reg <= done_next;
         req_reg <= req_next;
         busy_reg <= busy_next;
         ind_reg <= ind_next;
      end
   end
   // No sequence started while lockout holds; reset clears everything and pins stay idle
   assign busy_o = busy_reg;
   assign done_o = done_reg;
   assign err_o = err_reg;
   assign rdata_o = rd_reg;
   assign overlay_o = ovl_reg;
   assign factory_locked_o = fl_reg;
endmodule : srg_host

/* File: src/srg_params.svh */
// Constants for the secured-region host controller.
// Assumes a 200 MHz mclk_i and an asynchronous flash on plain pins.
//
// Summary of operation
// - Region programmed by standard sequences only.
// - Lock: three-cycle enter, then protect procedure.
// - Exit overlay before further main array access.
// - Host keeps enables inactive outside read and write cycles.
// - Write needs chip, write low, output high.
`ifndef SRG_PARAMS_SVH
`define SRG_PARAMS_SVH
`define SRG_CLK_MHZ 200
`define SRG_GLITCH_NS 5
// Strobe width rounded up to whole cycles, plus one margin cycle
`define SRG_STROBE_CYC ((`SRG_GLITCH_NS * `SRG_CLK_MHZ + 999) / 1000 + 1)
`define SRG_REGION_BYTES 256
`define SRG_IND_BIT 7
`define SRG_SN_BOT_BYTE 22'h000000
`define SRG_SN_TOP_BYTE 22'h3fff00
`define SRG_SN_BOT_WORD 22'h000000
`define SRG_SN_TOP_WORD 22'h1fff80
`define SRG_SN_BYTES 16
`define SRG_UNLK_A1 22'h000555
`define SRG_UNLK_A2 22'h0002aa
`define SRG_UNLK_D1 8'haa
`define SRG_UNLK_D2 8'h55
`endif

/* File: src/srg_pkg.sv */
// Types shared by the secured-region host controller.
// Assumes srg_params.svh supplies the numeric constants.
package srg_pkg;
   typedef enum logic [2:0] {
      SRG_OP_READ,
      SRG_OP_ENTER,
      SRG_OP_EXIT,
      SRG_OP_PROG,
      SRG_OP_LOCK
   } srg_op_t;
   typedef enum logic [1:0] {
      SRG_CY_IDLE,
      SRG_CY_SETUP,
      SRG_CY_STROBE,
      SRG_CY_HOLD
   } srg_cycle_t;
endpackage : srg_pkg

/* File: src/srg_bus_if.sv */
// Link between the sequencer and the pin cycle engine.
// Assumes one clock shared by both ends.
interface srg_bus_if;
   logic req;
   logic wr;
   logic [21:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic done;
   modport seq (output req, output wr, output addr, output wdata,
      input rdata, input done);
   modport eng (input req, input wr, input addr, input wdata,
      output rdata, output done);
endinterface : srg_bus_if

/* File: src/srg_cycle.sv */
// Pin cycle engine: one read or write on the flash pins per request.
// Assumes the flash samples on enable edges; timing from mclk_i.
`include "srg_params.svh"
module srg_cycle
   import srg_pkg::*;
(
   input wire logic mclk_i,
   input wire logic resetn_i,
   srg_bus_if.eng bus,
   // Flash pins
   output logic ce_n_o,
   output logic oe_n_o,
   output logic we_n_o,
   output logic [21:0] addr_o,
   output logic [7:0] dq_o,
   output logic dq_oe_o,
   input wire logic [7:0] dq_i
);
   srg_cycle_t st_reg, st_next;
   logic [3:0] cnt_reg, cnt_next;
   logic ce_reg, ce_next, oe_reg, oe_next, we_reg, we_next;
   logic [21:0] a_reg, a_next;
   logic [7:0] d_reg, d_next, rd_reg, rd_next;
   logic den_reg, den_next, wr_reg, wr_next, done_reg, done_next;
   always_comb begin
      st_next = st_reg;
      cnt_next = cnt_reg;
      ce_next = ce_reg;
      oe_next = oe_reg;
      we_next = we_reg;
      a_next = a_reg;
      d_next = d_reg;
      rd_next = rd_reg;
      den_next = den_reg;
      wr_next = wr_reg;
      done_next = 1'b0;
      case (st_reg)
         SRG_CY_IDLE: begin
            if (bus.req) begin
               a_next = bus.addr;
               d_next = bus.wdata;
               wr_next = bus.wr;
               den_next = bus.wr;
               ce_next = 1'b0;
               st_next = SRG_CY_SETUP;
            end
         end
         SRG_CY_SETUP: begin
            // Strobe is wide enough never to look like a glitch
            cnt_next = 4'(`SRG_STROBE_CYC);
            // Write only with output enable high; read never lowers we
            we_next = ~wr_reg;
            oe_next = wr_reg;
            st_next = SRG_CY_STROBE;
         end
         SRG_CY_STROBE: begin
            if (cnt_reg == 4'h0) begin
               rd_next = dq_i;
               we_next = 1'b1;
               oe_next = 1'b1;
               st_next = SRG_CY_HOLD;
            end else begin
               cnt_next = cnt_reg - 4'h1;
            end
         end
         SRG_CY_HOLD: begin
            // Enables return inactive between cycles
            ce_next = 1'b1;
            den_next = 1'b0;
            done_next = 1'b1;
            st_next = SRG_CY_IDLE;
         end
         default: st_next = SRG_CY_IDLE;
      endcase
   end
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         st_reg <= SRG_CY_IDLE;
         cnt_reg <= 4'h0;
         ce_reg <= 1'b1;
         oe_reg <= 1'b1;
         we_reg <= 1'b1;
         a_reg <= 22'h000000;
         d_reg <= 8'h00;
         rd_reg <= 8'h00;
         den_reg <= 1'b0;
         wr_reg <= 1'b0;
         done_reg <= 1'b0;
      end else begin
         st_reg <= st_next;
         cnt_reg <= cnt_next;
         ce_reg <= ce_next;
         oe_reg <= oe_next;
         we_reg <= we_next;
         a_reg <= a_next;
         d_reg <= d_next;
         rd_reg <= rd_next;
         den_reg <= den_next;
         wr_reg <= wr_next;
         done_reg <= done_next;
      end
   end
   assign ce_n_o = ce_reg;
   assign oe_n_o = oe_reg;
   assign we_n_o = we_reg;
   assign addr_o = a_reg;
   assign dq_o = d_reg;
   assign dq_oe_o = den_reg;
   assign bus.rdata = rd_reg;
   assign bus.done = done_reg;
endmodule : srg_cycle

/* File: testbench/srg_host_asserts.sv */
// Concurrent checks on the pins and command port of srg_host.
// Assumes binding onto srg_host; one clock, async active-low reset.
module srg_host_asserts
   import srg_pkg::*;
(
   // Clock and reset
   input wire logic mclk_i, resetn_i,
   // Command port
   input wire logic start_i,
   input wire srg_op_t op_i,
   input wire logic [7:0] offs_i, wdata_i, rdata_o,
   input wire logic busy_o, done_o, err_o, overlay_o, factory_locked_o,
   // Supply monitor
   input wire logic lockout_i,
   // Flash pins
   input wire logic ce_n_o, oe_n_o, we_n_o, dq_oe_o,
   input wire logic [21:0] addr_o,
   input wire logic [7:0] dq_o, dq_i
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!resetn_i);
   property p_wr_qual; !we_n_o |-> !ce_n_o && oe_n_o; endproperty
   a_wr_qual: assert property (p_wr_qual)
      else $error("write strobe without qualifiers");
   property p_wr_width; $fell(we_n_o) |=> !we_n_o [*2]; endproperty
   a_wr_width: assert property (p_wr_width)
      else $error("write strobe too short");
   property p_rd_width; $fell(oe_n_o) |=> !oe_n_o [*2]; endproperty
   a_rd_width: assert property (p_rd_width)
      else $error("read strobe too short");
   property p_idle;
      !busy_o && !done_o |-> ce_n_o && we_n_o && oe_n_o;
   endproperty
   a_idle: assert property (p_idle)
      else $error("enables active while idle");
   property p_no_clash; dq_oe_o |-> oe_n_o; endproperty
   a_no_clash: assert property (p_no_clash)
      else $error("data driven while output enabled");
   property p_lockout; lockout_i && !busy_o |=> !busy_o; endproperty
   a_lockout: assert property (p_lockout)
      else $error("sequence started in lockout");
   // Done is registered, so the lockout that decided it is one cycle back
   property p_lock_abort; $past(lockout_i) && done_o |-> err_o; endproperty
   a_lock_abort: assert property (p_lock_abort)
      else $error("sequence finished cleanly in lockout");
   property p_err_done; err_o |-> done_o; endproperty
   a_err_done: assert property (p_err_done)
      else $error("error without done");
   property p_locked_refuse;
      !busy_o && start_i && !lockout_i && factory_locked_o &&
         op_i == SRG_OP_PROG |-> ##[1:2] err_o;
   endproperty
   a_locked_refuse: assert property (p_locked_refuse)
      else $error("program of locked region not refused");
   property p_ovl_cause; $rose(overlay_o) |-> $past(busy_o); endproperty
   a_ovl_cause: assert property (p_ovl_cause)
      else $error("overlay set without a sequence");
   c_ok: cover property (done_o && !err_o);
   c_err: cover property (err_o);
   c_ovl: cover property ($rose(overlay_o));
endmodule : srg_host_asserts

/* File: testbench/srg_flash_model.sv */
// Behavioural flash: secured region, overlay and write guards.
// Assumes the unlock and command codes of the controller defaults.
module srg_flash_model (
   // Flash pins
   input wire logic ce_n, oe_n, we_n,
   input wire logic [21:0] addr,
   input wire logic [7:0] dq_w,
   // Board conditions
   input wire logic lockout, fact_lock,
   output logic [7:0] dq_r
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] mem [256];
   logic [2:0] st;
   logic ovl, lkd, ind;
   logic [7:0] last, rd;
   logic pu_inh;
   realtime t_fall;
   initial begin
      for (int i = 0; i < 256; i++) mem[i] = 8'hff;
      st = 3'h0;
      ovl = 1'b0;
      lkd = 1'b0;
      ind = 1'b0;
      last = 8'h00;
      pu_inh = 1'b1;
   end
   // Deselecting the chip ends the power-up window
   always @(posedge ce_n) pu_inh = 1'b0;
   always @(negedge we_n) t_fall = $realtime;
   always @(posedge lockout) begin
      st = 3'h0;
      ovl = 1'b0;
   end
   // Glitches and unqualified strobes never reach the decoder
   always @(posedge we_n) begin
      if (pu_inh) begin
         // Strobe still up from power-up is never a command
         pu_inh = 1'b0;
      end else if (!ce_n && oe_n && !lockout && $realtime - t_fall >= 5.0) begin
         case (st)
            3'h0: st = (addr[10:0] == 11'h555 && dq_w == 8'haa) ? 3'h1 : 3'h0;
            3'h1: st = (addr[10:0] == 11'h2aa && dq_w == 8'h55) ? 3'h2 : 3'h0;
            3'h2: begin
               st = 3'h0;
               if (dq_w == 8'h88) begin
                  ovl = 1'b1;
                  ind = 1'b1;
               end
               if (dq_w == 8'h90) st = 3'h3;
               if (dq_w == 8'ha0 && ovl) st = 3'h4;
               if (dq_w == 8'h60 && ovl) lkd = 1'b1;
            end
            3'h3: begin
               if (dq_w == 8'h00) ovl = 1'b0;
               st = 3'h0;
            end
            default: begin
               if (!(lkd || fact_lock)) mem[addr[7:0]] &= dq_w;
               st = 3'h0;
            end
         endcase
      end
   end
   assign rd = ind ? {fact_lock, 7'h00} :
      ovl ? mem[addr[7:0]] : addr[7:0] ^ 8'h5a;
   always @(posedge oe_n) begin
      if (!ce_n) begin
         last = rd;
         ind = 1'b0;
      end
   end
   // Released bus shows the inverse so stale data never matches
   assign dq_r = (!ce_n && !oe_n) ? rd : ~last;
endmodule : srg_flash_model

/* File: testbench/tb.sv */
// Self-checking bench for srg_host against the flash model.
// Assumes default command codes and bottom boot placement.
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   import srg_pkg::*;
   logic mclk_i = 1'b0, resetn_i = 1'b0, start_i = 1'b0, lockout_i = 1'b0;
   srg_op_t op_i = SRG_OP_READ;
   logic [7:0] offs_i = 8'h00, wdata_i = 8'h00, rdata_o, dq_o, dq_i, dq_r;
   logic busy_o, done_o, err_o, overlay_o, factory_locked_o;
   logic ce_n_o, oe_n_o, we_n_o, dq_oe_o, fact_lock = 1'b0;
   logic [21:0] addr_o;
   logic [7:0] exp_mem [256];
   logic [31:0] seed = 32'hb14c0e16;
   int fails = 0, checked = 0;
   logic [7:0] o, d;
   always #2.5 mclk_i = ~mclk_i;
   srg_host i_dut (.mclk_i(mclk_i), .resetn_i(resetn_i), .start_i(start_i),
      .op_i(op_i), .offs_i(offs_i), .wdata_i(wdata_i), .busy_o(busy_o),
      .done_o(done_o), .err_o(err_o), .rdata_o(rdata_o),
      .overlay_o(overlay_o), .factory_locked_o(factory_locked_o),
      .lockout_i(lockout_i), .ce_n_o(ce_n_o), .oe_n_o(oe_n_o),
      .we_n_o(we_n_o), .addr_o(addr_o), .dq_o(dq_o), .dq_oe_o(dq_oe_o),
      .dq_i(dq_i));
   srg_flash_model i_flash (.ce_n(ce_n_o), .oe_n(oe_n_o), .we_n(we_n_o),
      .addr(addr_o), .dq_w(dq_o), .lockout(lockout_i),
      .fact_lock(fact_lock), .dq_r(dq_r));
   assign dq_i = dq_oe_o ? dq_o : dq_r;
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : check
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : finish_test
   task automatic run_op(input srg_op_t op, input logic [7:0] of,
         input logic [7:0] wd, input logic exp_err);
      int n;
      @(posedge mclk_i);
      #1 start_i = 1'b1;
      op_i = op;
      offs_i = of;
      wdata_i = wd;
      @(posedge mclk_i);
      #1 start_i = 1'b0;
      n = 0;
      while (done_o !== 1'b1 && n < 200) begin
         @(posedge mclk_i);
         #1 n++;
      end
      // A hang never reaches done and counts as a mismatch
      check({7'h00, done_o}, 8'h01);
      check({7'h00, err_o}, {7'h00, exp_err});
   endtask : run_op
   task automatic flags(input logic ov, input logic fl);
      check({7'h00, overlay_o}, {7'h00, ov});
      check({7'h00, factory_locked_o}, {7'h00, fl});
   endtask : flags
   initial begin
      repeat (20000) @(posedge mclk_i);
      fails++;
      finish_test();
   end
   initial begin
      for (int i = 0; i < 256; i++) exp_mem[i] = 8'hff;
      repeat (5) @(posedge mclk_i);
      #1 resetn_i = 1'b1;
      flags(1'b0, 1'b0);
      run_op(SRG_OP_READ, 8'h00, 8'h00, 1'b1);
      run_op(SRG_OP_PROG, 8'h00, 8'h00, 1'b1);
      run_op(srg_op_t'(3'h5), 8'h00, 8'h00, 1'b1);
      run_op(SRG_OP_ENTER, 8'h00, 8'h00, 1'b0);
      flags(1'b1, 1'b0);
      $display("test refuse_enter done");
      for (int i = 0; i < 8; i++) begin
         seed = lfsr(seed);
         o = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : seed[7:0];
         d = seed[15:8];
         exp_mem[o] &= d;
         run_op(SRG_OP_PROG, o, d, 1'b0);
         run_op(SRG_OP_READ, o, 8'h00, 1'b0);
         check(rdata_o, exp_mem[o]);
      end
      $display("test program_read done");
      run_op(SRG_OP_LOCK, 8'h00, 8'h00, 1'b0);
      flags(1'b1, 1'b1);
      run_op(SRG_OP_PROG, o, 8'h00, 1'b1);
      run_op(SRG_OP_READ, o, 8'h00, 1'b0);
      check(rdata_o, exp_mem[o]);
      run_op(SRG_OP_EXIT, 8'h00, 8'h00, 1'b0);
      flags(1'b0, 1'b1);
      run_op(SRG_OP_READ, 8'h00, 8'h00, 1'b1);
      $display("test lock_exit done");
      @(posedge mclk_i);
      #1 lockout_i = 1'b1;
      start_i = 1'b1;
      op_i = SRG_OP_ENTER;
      repeat (12) begin
         @(posedge mclk_i);
         #1 check({7'h00, busy_o}, 8'h00);
      end
      start_i = 1'b0;
      lockout_i = 1'b0;
      fork
         run_op(SRG_OP_ENTER, 8'h00, 8'h00, 1'b1);
         begin
            repeat (12) @(posedge mclk_i);
            #1 lockout_i = 1'b1;
         end
      join
      flags(1'b0, 1'b1);
      @(posedge mclk_i);
      #1 lockout_i = 1'b0;
      $display("test lockout done");
      fact_lock = 1'b1;
      resetn_i = 1'b0;
      repeat (2) @(posedge mclk_i);
      #1 resetn_i = 1'b1;
      flags(1'b0, 1'b0);
      run_op(SRG_OP_ENTER, 8'h00, 8'h00, 1'b0);
      flags(1'b1, 1'b1);
      run_op(SRG_OP_PROG, 8'h10, 8'h00, 1'b1);
      $display("test factory_locked done");
      finish_test();
   end
endmodule : tb
bind srg_host srg_host_asserts i_chk (.mclk_i(mclk_i), .resetn_i(resetn_i),
   .start_i(start_i), .op_i(op_i), .offs_i(offs_i), .wdata_i(wdata_i),
   .rdata_o(rdata_o), .busy_o(busy_o), .done_o(done_o), .err_o(err_o),
   .overlay_o(overlay_o), .factory_locked_o(factory_locked_o),
   .lockout_i(lockout_i), .ce_n_o(ce_n_o), .oe_n_o(oe_n_o),
   .we_n_o(we_n_o), .dq_oe_o(dq_oe_o), .addr_o(addr_o), .dq_o(dq_o),
   .dq_i(dq_i));
